// ===== src/flash_host_defines.svh
// constants for the flash suspend and lock sequencing controller
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// software register offsets
`define OFS_CTRL 4'h0
`define OFS_ADDR 4'h4
`define OFS_STAT 4'h8

// control register fields
`define CTRL_OP_LSB 0
`define CTRL_GO_BIT 3
`define CTRL_AUTOCLR_BIT 4
`define CTRL_PDOWN_BIT 5
`define CTRL_WPROT_BIT 6
`define CTRL_RESET 7'h00

// flash status byte fields
`define SR_READY 7
`define SR_ERASE_SUSP 6
`define SR_ERASE_ERR 5
`define SR_WRITE_ERR 4
`define SR_SUPPLY_LOW 3
`define SR_WRITE_SUSP 2
`define SR_PROT_ABORT 1

// bus timing
`define CLK_PERIOD_NS 40
`define WE_LOW_NS 50
`define READ_ACCESS_NS 100
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACC_CYC ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/flash_host_pkg.sv
// types for the flash suspend and lock sequencing controller
package flash_host_pkg;

    typedef enum logic [2:0] {
        OP_ERASE_SUSPEND = 3'h0,
        OP_WRITE_SUSPEND = 3'h1,
        OP_RESUME = 3'h2,
        OP_SET_LOCK = 3'h3,
        OP_CLEAR_LOCKS = 3'h4,
        OP_CLEAR_STATUS = 3'h5,
        OP_READ_STATUS = 3'h6,
        OP_READ_ARRAY = 3'h7
    } host_op_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WSET = 6'b000010,
        ST_WLOW = 6'b000100,
        ST_WHOLD = 6'b001000,
        ST_RLOW = 6'b010000,
        ST_RCAP = 6'b100000
    } bus_state_t;

    // sequence steps of one operation
    typedef enum logic [1:0] {
        STEP_FIRST = 2'h0,
        STEP_SECOND = 2'h1,
        STEP_POLL = 2'h2,
        STEP_CLEAR = 2'h3
    } step_t;

endpackage

// ===== src/flash_host_ctrl.sv
// host-side controller that suspends, resumes and manages lock bits of a parallel flash
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_host_ctrl #(
    parameter int ADDR_W = 22,
    parameter logic [7:0] CMD_SUSPEND = 8'hb0,
    parameter logic [7:0] CMD_CONFIRM = 8'hd0,
    parameter logic [7:0] CMD_LOCK_SETUP = 8'h60,
    parameter logic [7:0] CMD_LOCK_SET = 8'h01,
    parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50,
    parameter logic [7:0] CMD_READ_STATUS = 8'h70,
    parameter logic [7:0] CMD_READ_ARRAY = 8'hff
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // flash pins
    output logic [ADDR_W-1:0] fl_addr,
    input wire logic [7:0] fl_dq_in,
    output logic [7:0] fl_dq_out,
    output logic fl_dq_oe_n,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic reset_powerdown_input_n,
    output logic fl_wp_n,
    input wire logic ready_status_output
);
    import flash_host_pkg::*;

    localparam logic [2:0] WE_CYC = 3'(`WE_LOW_CYC);
    localparam logic [2:0] ACC_CYC = 3'(`READ_ACC_CYC);

    bus_state_t state_reg, state_next;
    step_t step_reg, step_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [6:0] ctrl_reg, ctrl_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] sr_reg, sr_next;
    logic [3:0] err_reg, err_next;
    logic lock_unknown_reg, lock_unknown_next;
    logic erase_susp_reg, erase_susp_next;
    logic write_susp_reg, write_susp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [ADDR_W-1:0] fa_reg, fa_next;
    logic [7:0] dq_reg, dq_next;
    logic dq_oe_n_reg, dq_oe_n_next;
    logic ce_n_reg, ce_n_next;
    logic oe_n_reg, oe_n_next;
    logic we_n_reg, we_n_next;
    logic rp_n_reg, rp_n_next;
    logic wp_n_reg, wp_n_next;
    logic [7:0] cmd1, cmd2;
    logic two_writes, needs_poll;
    host_op_t op;
    logic busy;

    assign op = host_op_t'(ctrl_reg[`CTRL_OP_LSB +: 3]);
    // a pending go counts as busy, so a late write cannot swap the op under it
    assign busy = (state_reg != ST_IDLE) || ctrl_reg[`CTRL_GO_BIT];

    ////////////////////////////////////////////////////////////////////////
    // command bytes of each operation
    always_comb begin
        cmd1 = CMD_READ_STATUS;
        cmd2 = CMD_CONFIRM;
        two_writes = 1'b0;
        needs_poll = 1'b1;
        unique case (op)
            OP_ERASE_SUSPEND, OP_WRITE_SUSPEND: begin
                cmd1 = CMD_SUSPEND;
            end
            OP_RESUME: begin
                cmd1 = CMD_CONFIRM;
            end
            OP_SET_LOCK: begin
                cmd1 = CMD_LOCK_SETUP;
                cmd2 = CMD_LOCK_SET;
                two_writes = 1'b1;
            end
            OP_CLEAR_LOCKS: begin
                cmd1 = CMD_LOCK_SETUP;
                cmd2 = CMD_CONFIRM;
                two_writes = 1'b1;
            end
            OP_CLEAR_STATUS: begin
                cmd1 = CMD_CLEAR_STATUS;
                needs_poll = 1'b0;
            end
            OP_READ_STATUS: begin
                cmd1 = CMD_READ_STATUS;
            end
            OP_READ_ARRAY: begin
                cmd1 = CMD_READ_ARRAY;
                needs_poll = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of registers, bus sequencer and flash pins
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        cnt_next = cnt_reg;
        ctrl_next = ctrl_reg;
        addr_next = addr_reg;
        sr_next = sr_reg;
        err_next = err_reg;
        lock_unknown_next = lock_unknown_reg;
        erase_susp_next = erase_susp_reg;
        write_susp_next = write_susp_reg;
        rdata_next = 32'h0;
        fa_next = fa_reg;
        dq_next = dq_reg;
        dq_oe_n_next = dq_oe_n_reg;
        ce_n_next = ce_n_reg;
        oe_n_next = oe_n_reg;
        we_n_next = we_n_reg;
        // power-down stays released while an erase is suspended
        rp_n_next = ~(ctrl_reg[`CTRL_PDOWN_BIT] & ~erase_susp_reg & ~busy);

        // software port; go is ignored while busy
        if (reg_wr && reg_addr == `OFS_CTRL) begin
            ctrl_next = reg_wdata[6:0];
            if (busy) begin
                ctrl_next[`CTRL_OP_LSB +: 3] = ctrl_reg[`CTRL_OP_LSB +: 3];
            end
            ctrl_next[`CTRL_GO_BIT] = reg_wdata[`CTRL_GO_BIT] & ~busy;
        end
        if (reg_wr && reg_addr == `OFS_ADDR && !busy) begin
            addr_next = reg_wdata[ADDR_W-1:0];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_CTRL: rdata_next = {25'h0, ctrl_reg};
                `OFS_ADDR: rdata_next = 32'(addr_reg);
                `OFS_STAT: rdata_next = {16'h0, busy, lock_unknown_reg, erase_susp_reg,
                                         write_susp_reg, err_reg, sr_reg};
                default: rdata_next = 32'h0;
            endcase
        end
        // protect pin follows software; the device refuses lock changes while it is low
        wp_n_next = ctrl_reg[`CTRL_WPROT_BIT];

        unique case (state_reg)
            ST_IDLE: begin
                if (ctrl_reg[`CTRL_GO_BIT]) begin
                    ctrl_next[`CTRL_GO_BIT] = 1'b0;
                    step_next = STEP_FIRST;
                    if (op == OP_CLEAR_LOCKS) begin
                        lock_unknown_next = 1'b1;
                    end
                    state_next = ST_WSET;
                end
            end
            ST_WSET: begin
                ce_n_next = 1'b0;
                fa_next = addr_reg;
                dq_oe_n_next = 1'b0;
                unique case (step_reg)
                    STEP_SECOND: dq_next = cmd2;
                    STEP_CLEAR: dq_next = CMD_CLEAR_STATUS;
                    STEP_POLL: dq_next = CMD_READ_STATUS;
                    STEP_FIRST: dq_next = cmd1;
                endcase
                we_n_next = 1'b0;
                cnt_next = WE_CYC;
                state_next = ST_WLOW;
            end
            ST_WLOW: begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    we_n_next = 1'b1;
                    state_next = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                // data held one cycle past the rising write strobe
                dq_oe_n_next = 1'b1;
                ce_n_next = 1'b1;
                if (step_reg == STEP_FIRST && two_writes) begin
                    step_next = STEP_SECOND;
                    state_next = ST_WSET;
                end else if (step_reg == STEP_CLEAR || !needs_poll) begin
                    if (op == OP_CLEAR_STATUS || step_reg == STEP_CLEAR) begin
                        err_next = 4'h0;
                    end
                    state_next = ST_IDLE;
                end else begin
                    // after the command the device already presents status
                    step_next = STEP_POLL;
                    state_next = ST_RLOW;
                    ce_n_next = 1'b0;
                    oe_n_next = 1'b0;
                    cnt_next = ACC_CYC;
                end
            end
            ST_RLOW: begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    state_next = ST_RCAP;
                end
            end
            ST_RCAP: begin
                oe_n_next = 1'b1;
                ce_n_next = 1'b1;
                // low bits mean nothing until the ready bit is one
                if (fl_dq_in[`SR_READY] && ready_status_output) begin
                    sr_next = {fl_dq_in[7:1], 1'b0};
                    erase_susp_next = fl_dq_in[`SR_ERASE_SUSP];
                    write_susp_next = fl_dq_in[`SR_WRITE_SUSP];
                    err_next = err_reg | {fl_dq_in[`SR_ERASE_ERR], fl_dq_in[`SR_WRITE_ERR],
                                          fl_dq_in[`SR_SUPPLY_LOW], fl_dq_in[`SR_PROT_ABORT]};
                    if (op == OP_CLEAR_LOCKS) begin
                        lock_unknown_next = fl_dq_in[`SR_ERASE_ERR];
                    end
                    if (ctrl_reg[`CTRL_AUTOCLR_BIT] &&
                        (fl_dq_in[`SR_ERASE_ERR] || fl_dq_in[`SR_WRITE_ERR])) begin
                        step_next = STEP_CLEAR;
                        state_next = ST_WSET;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end else begin
                    state_next = ST_RLOW;
                    ce_n_next = 1'b0;
                    oe_n_next = 1'b0;
                    cnt_next = ACC_CYC;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            step_reg <= STEP_FIRST;
            cnt_reg <= 3'h0;
            ctrl_reg <= `CTRL_RESET;
            addr_reg <= '0;
            sr_reg <= 8'h80;
            err_reg <= 4'h0;
            lock_unknown_reg <= 1'b0;
            erase_susp_reg <= 1'b0;
            write_susp_reg <= 1'b0;
            rdata_reg <= 32'h0;
            fa_reg <= '0;
            dq_reg <= 8'h00;
            dq_oe_n_reg <= 1'b1;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            rp_n_reg <= 1'b1;
            wp_n_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            sr_reg <= sr_next;
            err_reg <= err_next;
            lock_unknown_reg <= lock_unknown_next;
            erase_susp_reg <= erase_susp_next;
            write_susp_reg <= write_susp_next;
            rdata_reg <= rdata_next;
            fa_reg <= fa_next;
            dq_reg <= dq_next;
            dq_oe_n_reg <= dq_oe_n_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            rp_n_reg <= rp_n_next;
            wp_n_reg <= wp_n_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign fl_addr = fa_reg;
    assign fl_dq_out = dq_reg;
    assign fl_dq_oe_n = dq_oe_n_reg;
    assign fl_ce_n = ce_n_reg;
    assign fl_oe_n = oe_n_reg;
    assign fl_we_n = we_n_reg;
    assign reset_powerdown_input_n = rp_n_reg;
    assign fl_wp_n = wp_n_reg;

endmodule

// ===== verification/flash_host_ctrl_assertions.sv
// checker of flash pin and register port timing for the flash controller
`timescale 1ns/1ps
module flash_host_checker #(
    parameter logic [7:0] CMD_LOCK_SETUP = 8'h60
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // software register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // flash pins
    input wire logic [7:0] fl_dq_out,
    input wire logic fl_dq_oe_n,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_we_low_two: assert property ($fell(fl_we_n) |-> ##1 !fl_we_n ##1 fl_we_n)
        else $error("write strobe width wrong");
    a_data_hold: assert property ($rose(fl_we_n) |-> !fl_dq_oe_n && $stable(fl_dq_out))
        else $error("command data not held past strobe");
    a_we_in_ce: assert property (!fl_we_n |-> !fl_ce_n)
        else $error("write strobe without chip enable");
    a_no_fight: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
        else $error("read while driving data");
    a_oe_three: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*3])
        else $error("status read strobe too short");
    a_oe_in_ce: assert property (!fl_oe_n |-> !fl_ce_n)
        else $error("read strobe without chip enable");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_setup_confirm: assert property ($rose(fl_we_n) && fl_dq_out == CMD_LOCK_SETUP
        |-> ##[1:8] $fell(fl_we_n))
        else $error("confirm write did not follow setup");
endmodule

bind flash_host_ctrl flash_host_checker #(.CMD_LOCK_SETUP(CMD_LOCK_SETUP)) u_flash_host_checker (
    .mclk(mclk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n));

// ===== verification/flash_dev_model.sv
// behavioural flash device answering the controller's pins
`timescale 1ns/1ps
module flash_dev_model (
    // clock and bench controls
    input wire logic mclk,
    input wire logic vpp_low,
    input wire logic start_erase,
    input wire logic start_write,
    // flash pins
    input wire logic [21:0] fl_addr,
    input wire logic [7:0] fl_dq_out,
    input wire logic fl_dq_oe_n,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic fl_wp_n,
    output logic [7:0] fl_dq_in,
    output logic ready_status_output,
    output logic [63:0] lock_bits = 64'h0
);
    logic [7:0] er_cnt = 8'h0, wr_cnt = 8'h0, op_cnt = 8'h0, lat = 8'h0, last = 8'h0;
    logic es = 1'b0, ws = 1'b0, pend = 1'b0, we_q = 1'b1;
    logic [3:0] err = 4'h0; // {erase/clear, write/set, supply low, protect}
    logic busy;
    logic [7:0] sb;
    assign busy = (er_cnt != 0 && !es) || (wr_cnt != 0 && !ws) || op_cnt != 0;
    assign sb = {!busy, es, err[3:1], ws, err[0], 1'b0};
    assign ready_status_output = !busy; // floats to pull-up when ready
    // released bus shows the inverse of its last value, never a kind constant
    assign fl_dq_in = !fl_dq_oe_n ? fl_dq_out : (!fl_oe_n && !fl_ce_n) ? sb : ~last;
    always @(posedge mclk) begin
        we_q <= fl_we_n;
        last <= fl_dq_in;
        if (lat == 8'h1 && wr_cnt != 0 && !ws) ws <= 1'b1;
        else if (lat == 8'h1 && er_cnt != 0) es <= 1'b1;
        if (lat != 0) lat <= lat - 8'h1;
        if (er_cnt != 0 && !es) er_cnt <= er_cnt - 8'h1;
        if (wr_cnt != 0 && !ws) wr_cnt <= wr_cnt - 8'h1;
        if (op_cnt != 0) op_cnt <= op_cnt - 8'h1;
        if (start_erase) er_cnt <= 8'd60;
        if (start_write && (es || er_cnt == 0)) wr_cnt <= 8'd20;
        if (fl_we_n && !we_q && !fl_ce_n) begin
            pend <= 1'b0;
            if (pend && fl_dq_out == 8'h01 && !fl_wp_n) err <= err | 4'h5;
            else if (pend && fl_dq_out == 8'h01) lock_bits[fl_addr[21:16]] <= 1'b1;
            else if (pend && fl_dq_out == 8'hd0 && !fl_wp_n) err <= err | 4'h9;
            else if (pend && fl_dq_out == 8'hd0 && vpp_low) err <= err | 4'ha;
            else if (pend && fl_dq_out == 8'hd0) lock_bits <= 64'h0;
            else if (pend) err <= err | 4'hc;
            else if (fl_dq_out == 8'h60) pend <= 1'b1;
            else if (fl_dq_out == 8'hb0) lat <= 8'd3;
            else if (fl_dq_out == 8'hd0 && ws) ws <= 1'b0;
            else if (fl_dq_out == 8'hd0 && es && wr_cnt == 0) es <= 1'b0;
            else if (fl_dq_out == 8'h50) err <= 4'h0;
            if (pend) op_cnt <= 8'd6;
        end
    end
endmodule

// ===== verification/flash_host_ctrl_bench.sv
// self-checking bench for the flash suspend and lock controller
`timescale 1ns/1ps
`include "flash_host_defines.svh"
module flash_host_ctrl_bench;
    import flash_host_pkg::*;
    logic mclk, sys_rst, reg_wr, reg_rd, vpp_low, start_erase, start_write;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, stat;
    logic [21:0] fl_addr;
    logic [7:0] fl_dq_in, fl_dq_out;
    logic fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, pd_n, fl_wp_n, ready_status_output;
    logic [63:0] lock_bits;
    int errors = 0;
    int cmp_count = 0;
    flash_host_ctrl u_flash_host_ctrl (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n),
        .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .reset_powerdown_input_n(pd_n),
        .fl_wp_n(fl_wp_n), .ready_status_output(ready_status_output));
    flash_dev_model u_flash_dev_model (.mclk(mclk), .vpp_low(vpp_low), .start_erase(start_erase),
        .start_write(start_write), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
        .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .fl_wp_n(fl_wp_n), .fl_dq_in(fl_dq_in), .ready_status_output(ready_status_output),
        .lock_bits(lock_bits));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        stat = reg_rdata;
    endtask
    task automatic pulse(input logic erase);
        @(posedge mclk);
        start_erase <= erase;
        start_write <= !erase;
        @(posedge mclk);
        start_erase <= 1'b0;
        start_write <= 1'b0;
        #1;
    endtask
    // polls until idle; a bounded wait keeps a stuck sequence from hanging the run
    task automatic poll_idle;
        int n;
        n = 0;
        stat = 32'h8000;
        repeat (2) @(posedge mclk);
        while (stat[15] && n < 100) begin
            rd(`OFS_STAT);
            n++;
        end
        chk({31'h0, stat[15]}, 32'h0);
    endtask
    task automatic do_op(input logic [2:0] op, input logic wp);
        wr(`OFS_CTRL, {25'h0, wp, 2'b00, 1'b1, op});
        poll_idle();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        #1;
        chk({28'h0, pd_n, fl_wp_n, fl_we_n, fl_ce_n}, 32'hb);
        rd(`OFS_STAT);
        chk(stat, 32'h80);
        rd(4'hc);
        chk(stat, 32'h0);
        wr(`OFS_CTRL, 32'h20);
        repeat (2) @(posedge mclk);
        #1;
        chk({31'h0, pd_n}, 32'h0);
        wr(`OFS_CTRL, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_erase;
        pulse(1'b1);
        do_op(OP_ERASE_SUSPEND, 1'b1);
        chk(stat & 32'h20ff, 32'h20c0);
        chk({31'h0, ready_status_output}, 32'h1);
        wr(`OFS_CTRL, 32'h60);
        repeat (4) @(posedge mclk);
        chk({31'h0, pd_n}, 32'h1);
        pulse(1'b0);
        chk({31'h0, ready_status_output}, 32'h0);
        do_op(OP_RESUME, 1'b1);
        chk(stat & 32'h20ff, 32'h20c0);
        do_op(OP_READ_STATUS, 1'b1);
        chk(stat & 32'h20ff, 32'h20c0);
        do_op(OP_RESUME, 1'b1);
        chk(stat & 32'h20ff, 32'h0080);
        $display("test erase suspend done");
    endtask
    task automatic t_write;
        pulse(1'b0);
        do_op(OP_WRITE_SUSPEND, 1'b1);
        chk(stat & 32'h10ff, 32'h1084);
        do_op(OP_RESUME, 1'b1);
        chk(stat & 32'h10ff, 32'h0080);
        $display("test write suspend done");
    endtask
    task automatic t_lock;
        wr(`OFS_ADDR, 32'h10000);
        rd(`OFS_ADDR);
        chk(stat, 32'h10000);
        do_op(OP_SET_LOCK, 1'b1);
        chk(stat & 32'h0fff, 32'h0080);
        chk({31'h0, lock_bits[1]}, 32'h1);
        do_op(OP_SET_LOCK, 1'b0);
        chk(stat & 32'h0fff, 32'h0592);
        do_op(OP_READ_STATUS, 1'b1);
        chk(stat & 32'h0f00, 32'h0500);
        do_op(OP_CLEAR_STATUS, 1'b1);
        chk(stat & 32'h0f00, 32'h0);
        wr(`OFS_CTRL, 32'h1b);
        poll_idle();
        chk(stat & 32'h0fff, 32'h0092);
        do_op(OP_READ_STATUS, 1'b1);
        chk(stat & 32'h0fff, 32'h0080);
        $display("test set lock done");
    endtask
    task automatic t_clear;
        do_op(OP_CLEAR_LOCKS, 1'b0);
        chk(stat & 32'h0fff, 32'h09a2);
        do_op(OP_CLEAR_STATUS, 1'b1);
        vpp_low <= 1'b1;
        do_op(OP_CLEAR_LOCKS, 1'b1);
        chk(stat & 32'h4fff, 32'h4aa8);
        chk({31'h0, lock_bits[1]}, 32'h1);
        do_op(OP_CLEAR_STATUS, 1'b1);
        vpp_low <= 1'b0;
        do_op(OP_CLEAR_LOCKS, 1'b1);
        chk(stat & 32'h4fff, 32'h0080);
        chk({31'h0, |lock_bits}, 32'h0);
        $display("test clear locks done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #(40 * 20000);
        errors++;
        wrap_up();
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, vpp_low, start_erase, start_write} = 6'h20;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_erase();
        t_write();
        t_lock();
        t_clear();
        wrap_up();
    end
endmodule
